// ### design/fsotp_defines.svh
`ifndef FSOTP_DEFINES_SVH
`define FSOTP_DEFINES_SVH

// ****************************************
// Command codes
// ****************************************
`define FSOTP_CMD_OTP_READ   8'h77
`define FSOTP_CMD_STAT_READ  8'h05
`define FSOTP_CMD_STAT_WRITE 8'h01
`define FSOTP_CMD_WR_EN      8'h06
`define FSOTP_CMD_WR_DIS     8'h04
`define FSOTP_CMD_OTP_PROG   8'h9b
`define FSOTP_CMD_PAGE_PROG  8'h02
`define FSOTP_CMD_ERASE_PAGE 8'h81
`define FSOTP_CMD_ERASE_4K   8'h20
`define FSOTP_CMD_ERASE_32K  8'h52
`define FSOTP_CMD_ERASE_CHIP 8'h60
`define FSOTP_CMD_ERASE_ALT  8'hc7

// ****************************************
// Status byte one fields
// ****************************************
`define FSOTP_BIT_LOCK  7
`define FSOTP_BIT_RES6  6
`define FSOTP_BIT_ERR   5
`define FSOTP_BIT_WPP   4
`define FSOTP_BIT_RES3  3
`define FSOTP_BIT_PROT  2
`define FSOTP_BIT_WEL   1
`define FSOTP_BIT_BUSY  0

// ****************************************
// Reset values and sizes
// ****************************************
`define FSOTP_RST_LOCK  1'b0
`define FSOTP_RST_PROT  1'b0
`define FSOTP_RST_WEL   1'b0
`define FSOTP_RST_ERR   1'b0
`define FSOTP_OTP_DEPTH 128
`define FSOTP_OTP_LAST  7'h7f
`define FSOTP_ADDR_LAST 2'h2
`define FSOTP_DUMMY_LAST 2'h1

`endif

// ### design/fsotp_pkg.sv
package fsotp_pkg;

	typedef logic [7:0] fsotp_code_t;

	typedef enum logic [2:0] {
		FSOTP_ST_OP,
		FSOTP_ST_ADDR,
		FSOTP_ST_DUMMY,
		FSOTP_ST_OTP,
		FSOTP_ST_STAT,
		FSOTP_ST_WDATA,
		FSOTP_ST_IGNORE
	} fsotp_state_t;

endpackage

// ### design/fsotp_core.sv
`timescale 1ns/1ps
`include "fsotp_defines.svh"

// How it works
// - Security read: chip select, code 77h, then three start-address bytes.
// - Two dummy bytes follow the address; no output before they end.
// - Security bytes stream out, wrapping 7Fh to 00h without gaps.
// - Chip select release ends the security read and floats output at once.
// - Status read: code 05h, then one status bit per following clock.
// - Status read is answered at any time, even while busy.
// - Byte one then byte two, MSB first, repeating with live values.
// - Chip select release ends the status read and floats output.
// - Byte one bit 0 shows busy, read only.
// - Byte one bits 6 and 3 read zero.
// - Status write changes only lock bit 7 and protect bit 2.
// - Lock set with pin asserted freezes the array-protect bit.
// - Lock bit is zero after power-up.
// - With pin asserted, lock may only go from 0 to 1.
// - Error flag reflects failure of the latest erase or program.
// - Aborted erase or program leaves the error flag alone.
// - Bit 4 reads 0 with pin asserted, 1 otherwise.
// - Array-protect set rejects all array program and erase.
// - With write latch clear, write-type commands are ignored.
// - Write latch is zero after power-up or reset operation.
// - Write latch clears on write disable and write-type completion or abort.
// - Incomplete or unknown opcodes leave the write latch set.
module fsotp_core (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	input  wire logic                 sck,
	input  wire logic                 cs_b,
	input  wire logic                 si,
	output logic                      so,
	output logic                      so_oe_b,
	input  wire logic                 wp_b,
	input  wire logic                 core_busy,
	input  wire logic                 core_done,
	input  wire logic                 core_fail,
	input  wire logic                 hold_abort,
	input  wire logic                 soft_reset,
	output logic                      op_start,
	output fsotp_pkg::fsotp_code_t    op_code,
	output logic [23:0]               op_addr,
	input  wire logic                 otp_wr_en,
	input  wire logic [6:0]           otp_wr_addr,
	input  wire logic [7:0]           otp_wr_data
);
	import fsotp_pkg::*;

	// ****************************************
	// Command classes
	// ****************************************
	function automatic logic is_array_op(input fsotp_code_t c);
		is_array_op = (c == `FSOTP_CMD_PAGE_PROG) || (c == `FSOTP_CMD_ERASE_PAGE) ||
			(c == `FSOTP_CMD_ERASE_4K) || (c == `FSOTP_CMD_ERASE_32K) ||
			(c == `FSOTP_CMD_ERASE_CHIP) || (c == `FSOTP_CMD_ERASE_ALT);
	endfunction

	function automatic logic needs_addr(input fsotp_code_t c);
		needs_addr = (c == `FSOTP_CMD_OTP_READ) || (c == `FSOTP_CMD_OTP_PROG) ||
			(is_array_op(c) && c != `FSOTP_CMD_ERASE_CHIP && c != `FSOTP_CMD_ERASE_ALT);
	endfunction

	// ****************************************
	// Security area storage
	// ****************************************
	// Written by the programming engine on clk_sys; read on sck in any
	// security read, with no check of busy or of a running program.
	logic [7:0] otp_mem [`FSOTP_OTP_DEPTH];

	always_ff @(posedge clk_sys) begin
		if (otp_wr_en) begin
			otp_mem[otp_wr_addr] <= otp_wr_data;
		end
	end

	// ****************************************
	// Link side, sck domain
	// ****************************************
	fsotp_state_t state_reg;
	logic [2:0]   bit_reg;
	logic [1:0]   cnt_reg;
	logic [3:0]   stat_cnt_reg;
	logic [6:0]   sh_reg;
	fsotp_code_t  code_reg;
	logic [23:0]  addr_reg;
	logic         rec_op_full_reg;
	logic         rec_addr_full_reg;
	logic         rec_data_full_reg;
	logic         rec_aligned_reg;
	logic [7:0]   rec_data_reg;
	logic [7:0]   stat_s1_reg;
	logic [7:0]   stat_s2_reg;
	logic [7:0]   status_reg;
	logic [7:0]   byte_in;
	logic         byte_done;
	logic         first_edge;
	logic         link_clr;
	logic [15:0]  stat_word;

	// Frame logic is cleared by a released chip select, since sck stops
	assign link_clr   = cs_b | ~rst_b;
	assign byte_in    = {sh_reg, si};
	assign byte_done  = (bit_reg == 3'h7);
	assign first_edge = (state_reg == FSOTP_ST_OP) && (bit_reg == 3'h0);
	// Byte two carries only busy here; its other bits read zero
	assign stat_word  = {stat_s2_reg, 7'h00, stat_s2_reg[`FSOTP_BIT_BUSY]};

	always_ff @(posedge sck or negedge rst_b) begin
		if (!rst_b) begin
			stat_s1_reg <= 8'h00;
			stat_s2_reg <= 8'h00;
		end else begin
			stat_s1_reg <= status_reg;
			stat_s2_reg <= stat_s1_reg;
		end
	end

	always_ff @(posedge sck or posedge link_clr) begin
		if (link_clr) begin
			state_reg    <= FSOTP_ST_OP;
			bit_reg      <= 3'h0;
			cnt_reg      <= 2'h0;
			stat_cnt_reg <= 4'h0;
			sh_reg       <= 7'h00;
		end else begin
			bit_reg <= bit_reg + 3'h1;
			sh_reg  <= byte_in[6:0];
			case (state_reg)
				FSOTP_ST_OP: begin
					if (byte_done) begin
						cnt_reg <= 2'h0;
						if (byte_in == `FSOTP_CMD_STAT_READ) begin
							state_reg    <= FSOTP_ST_STAT;
							stat_cnt_reg <= 4'h0;
						end else if (needs_addr(byte_in)) begin
							state_reg <= FSOTP_ST_ADDR;
						end else if (byte_in == `FSOTP_CMD_STAT_WRITE) begin
							state_reg <= FSOTP_ST_WDATA;
						end else begin
							state_reg <= FSOTP_ST_IGNORE;
						end
					end
				end
				FSOTP_ST_ADDR: begin
					if (byte_done) begin
						cnt_reg <= cnt_reg + 2'h1;
						if (cnt_reg == `FSOTP_ADDR_LAST) begin
							cnt_reg   <= 2'h0;
							state_reg <= (code_reg == `FSOTP_CMD_OTP_READ) ? FSOTP_ST_DUMMY : FSOTP_ST_IGNORE;
						end
					end
				end
				FSOTP_ST_DUMMY: begin
					if (byte_done) begin
						cnt_reg <= cnt_reg + 2'h1;
						if (cnt_reg == `FSOTP_DUMMY_LAST) begin
							state_reg <= FSOTP_ST_OTP;
						end
					end
				end
				FSOTP_ST_STAT: begin
					stat_cnt_reg <= stat_cnt_reg + 4'h1;
				end
				FSOTP_ST_WDATA: begin
					if (byte_done) begin
						state_reg <= FSOTP_ST_IGNORE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Frame record; survives the release so clk_sys can read it afterwards
	always_ff @(posedge sck or negedge rst_b) begin
		if (!rst_b) begin
			code_reg          <= 8'h00;
			addr_reg          <= 24'h000000;
			rec_op_full_reg   <= 1'b0;
			rec_addr_full_reg <= 1'b0;
			rec_data_full_reg <= 1'b0;
			rec_aligned_reg   <= 1'b0;
			rec_data_reg      <= 8'h00;
		end else begin
			rec_aligned_reg <= byte_done;
			if (first_edge) begin
				rec_op_full_reg   <= 1'b0;
				rec_addr_full_reg <= 1'b0;
				rec_data_full_reg <= 1'b0;
			end
			if (state_reg == FSOTP_ST_OP && byte_done) begin
				code_reg        <= byte_in;
				rec_op_full_reg <= 1'b1;
			end
			if (state_reg == FSOTP_ST_ADDR && byte_done) begin
				addr_reg <= {addr_reg[15:0], byte_in};
				if (cnt_reg == `FSOTP_ADDR_LAST) begin
					rec_addr_full_reg <= 1'b1;
				end
			end
			if (state_reg == FSOTP_ST_OTP && byte_done) begin
				addr_reg[6:0] <= addr_reg[6:0] + 7'h01;
			end
			if (state_reg == FSOTP_ST_WDATA && byte_done) begin
				rec_data_reg      <= byte_in;
				rec_data_full_reg <= 1'b1;
			end
		end
	end

	// Output launches on the falling edge, one half period before sampling
	always_ff @(negedge sck or posedge link_clr) begin
		if (link_clr) begin
			so      <= 1'b0;
			so_oe_b <= 1'b1;
		end else if (state_reg == FSOTP_ST_OTP) begin
			so      <= otp_mem[addr_reg[6:0]][~bit_reg];
			so_oe_b <= 1'b0;
		end else if (state_reg == FSOTP_ST_STAT) begin
			so      <= stat_word[~stat_cnt_reg];
			so_oe_b <= 1'b0;
		end else begin
			so      <= 1'b0;
			so_oe_b <= 1'b1;
		end
	end

	// ****************************************
	// System side, clk_sys domain
	// ****************************************
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic wp_s1_reg;
	logic wp_s2_reg;
	logic lock_reg;
	logic prot_reg;
	logic wel_reg;
	logic err_reg;
	logic pending_reg;
	logic frame_end;
	logic wp_on;
	logic wr_cmd;
	logic op_ok;
	logic op_abort;
	logic lock_clear_refused;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			wp_s1_reg <= 1'b1;
			wp_s2_reg <= 1'b1;
		end else begin
			cs_s1_reg <= cs_b;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			wp_s1_reg <= wp_b;
			wp_s2_reg <= wp_s1_reg;
		end
	end

	// Record is stable: sck is idle once chip select has been high this long
	assign frame_end = cs_s2_reg & ~cs_s3_reg & rec_op_full_reg;
	assign wp_on     = ~wp_s2_reg;
	assign wr_cmd    = is_array_op(code_reg) || (code_reg == `FSOTP_CMD_OTP_PROG);
	assign op_ok     = rec_aligned_reg && (rec_addr_full_reg || !needs_addr(code_reg)) &&
		!(prot_reg && is_array_op(code_reg)) && !core_busy;
	assign op_abort  = frame_end && wr_cmd && wel_reg && !op_ok;
	assign lock_clear_refused = wp_on && lock_reg && !rec_data_reg[`FSOTP_BIT_LOCK];

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lock_reg <= `FSOTP_RST_LOCK;
			prot_reg <= `FSOTP_RST_PROT;
		end else if (frame_end && code_reg == `FSOTP_CMD_STAT_WRITE && wel_reg && !core_busy &&
			rec_data_full_reg && rec_aligned_reg && !lock_clear_refused) begin
			lock_reg <= rec_data_reg[`FSOTP_BIT_LOCK];
			if (!(lock_reg && wp_on)) begin
				prot_reg <= rec_data_reg[`FSOTP_BIT_PROT];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wel_reg <= `FSOTP_RST_WEL;
		end else if (frame_end && code_reg == `FSOTP_CMD_WR_EN && rec_aligned_reg && !core_busy) begin
			wel_reg <= 1'b1;
		end else if (soft_reset || hold_abort || (pending_reg && core_done)) begin
			wel_reg <= 1'b0;
		end else if (frame_end && (code_reg == `FSOTP_CMD_WR_DIS || op_abort ||
			(wr_cmd && op_ok) || code_reg == `FSOTP_CMD_STAT_WRITE)) begin
			wel_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			op_start    <= 1'b0;
			op_code     <= 8'h00;
			op_addr     <= 24'h000000;
			pending_reg <= 1'b0;
		end else begin
			op_start <= frame_end && wr_cmd && wel_reg && op_ok;
			if (frame_end && wr_cmd && wel_reg && op_ok) begin
				op_code     <= code_reg;
				op_addr     <= addr_reg;
				pending_reg <= 1'b1;
			end else if (core_done) begin
				pending_reg <= 1'b0;
			end
		end
	end

	// Only a run that really started refreshes the flag; aborts never reach here
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			err_reg <= `FSOTP_RST_ERR;
		end else if (pending_reg && core_done) begin
			err_reg <= core_fail;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= 8'h00;
		end else begin
			status_reg[`FSOTP_BIT_LOCK] <= lock_reg;
			status_reg[`FSOTP_BIT_RES6] <= 1'b0;
			status_reg[`FSOTP_BIT_ERR]  <= err_reg;
			status_reg[`FSOTP_BIT_WPP]  <= wp_s2_reg;
			status_reg[`FSOTP_BIT_RES3] <= 1'b0;
			status_reg[`FSOTP_BIT_PROT] <= prot_reg;
			status_reg[`FSOTP_BIT_WEL]  <= wel_reg;
			status_reg[`FSOTP_BIT_BUSY] <= core_busy | pending_reg;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	otp_wrap_a: assert property (@(posedge sck) disable iff (link_clr)
		(state_reg == FSOTP_ST_OTP && byte_done && addr_reg[6:0] == `FSOTP_OTP_LAST)
		|=> (state_reg == FSOTP_ST_OTP && addr_reg[6:0] == 7'h00 && bit_reg == 3'h0))
		else $error("security address did not wrap to zero");

	dummy_len_a: assert property (@(posedge sck) disable iff (link_clr)
		(state_reg == FSOTP_ST_DUMMY && bit_reg == 3'h0 && cnt_reg == 2'h0)
		|-> ##15 (state_reg == FSOTP_ST_DUMMY && so_oe_b) ##1 (state_reg == FSOTP_ST_OTP))
		else $error("dummy phase length wrong");

	quiet_phase_a: assert property (@(posedge sck) disable iff (link_clr)
		(state_reg inside {FSOTP_ST_OP, FSOTP_ST_ADDR, FSOTP_ST_DUMMY, FSOTP_ST_WDATA}) |-> so_oe_b)
		else $error("output driven outside data phase");

	stat_entry_a: assert property (@(posedge sck) disable iff (link_clr)
		(state_reg == FSOTP_ST_OP && byte_done && byte_in == `FSOTP_CMD_STAT_READ)
		|=> (state_reg == FSOTP_ST_STAT && stat_cnt_reg == 4'h0) ##1 (!so_oe_b && stat_cnt_reg == 4'h1))
		else $error("status read not started");

	stat_reserved_a: assert property (@(posedge sck) disable iff (link_clr)
		(state_reg == FSOTP_ST_STAT && (stat_cnt_reg == 4'h1 || stat_cnt_reg == 4'h4)) |-> !so)
		else $error("reserved status bit not zero");

	release_float_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cs_s2_reg |-> so_oe_b)
		else $error("output driven after release");

	wsr_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(frame_end && code_reg == `FSOTP_CMD_STAT_WRITE) |=> !wel_reg)
		else $error("write latch kept after status write");

	prot_frozen_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(frame_end && lock_reg && wp_on) |=> $stable(prot_reg))
		else $error("array protect changed while locked");

	lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(lock_reg && wp_on) |=> lock_reg)
		else $error("lock cleared with pin asserted");

	abort_err_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(op_abort && !(pending_reg && core_done)) |=> ($stable(err_reg) && !op_start))
		else $error("abort touched error flag");

	ignore_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(frame_end && !wel_reg) |=> !op_start)
		else $error("write command ran without write latch");

	wrap_c: cover property (@(posedge sck) disable iff (link_clr)
		state_reg == FSOTP_ST_OTP && byte_done && addr_reg[6:0] == `FSOTP_OTP_LAST);

	stat_pass_c: cover property (@(posedge sck) disable iff (link_clr)
		state_reg == FSOTP_ST_STAT && stat_cnt_reg == 4'hf ##1 stat_cnt_reg == 4'h0);

	wsr_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
		frame_end && code_reg == `FSOTP_CMD_STAT_WRITE && wel_reg && !lock_clear_refused);

	start_c: cover property (@(posedge clk_sys) disable iff (!rst_b) op_start);

endmodule

// ### verification/fsotp_spi_host.sv
`timescale 1ns/1ps
module fsotp_spi_host (
	output logic      cs_b,
	output logic      sck,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe_b
);
	// ****
	// Mode 0 host, sck stands still between frames
	// ****
	localparam int HALF = 16;

	initial begin
		cs_b = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
		output logic [63:0] rx, output logic oe_ok);
		rx    = '0;
		oe_ok = 1'b1;
		cs_b  = 1'b0;
		for (int i = 0; i < ntx + nrx; i++) begin
			// Toggling si in the data phase so a stale bit is never mistaken for a held one
			si = (i < ntx) ? tx[ntx-1-i] : ~si;
			#HALF sck = 1'b1;
			if (so_oe_b !== ((i < ntx) ? 1'b1 : 1'b0)) oe_ok = 1'b0;
			if (i >= ntx) rx = {rx[62:0], so};
			#HALF sck = 1'b0;
		end
		#HALF cs_b = 1'b1;
		#1 if (so_oe_b !== 1'b1) oe_ok = 1'b0;
		// Gap well above four system cycles for the frame record
		#200;
	endtask
endmodule

// ### verification/flash_status_and_otp_read_tb.sv
`timescale 1ns/1ps
module flash_status_and_otp_read_tb;
	import fsotp_pkg::*;
	`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
		$display("Error %0t: got %h expected %h", $time, g, e); end end

	logic        clk_sys, rst_b, sck, cs_b, si, so, so_oe_b, wp_b;
	logic        core_busy, core_done, core_fail, hold_abort, soft_reset, op_start;
	logic        otp_wr_en, ok, lock_e, prot_e, err_e, wel_e;
	fsotp_code_t op_code, cap_code;
	logic [23:0] op_addr, cap_addr, a;
	logic [6:0]  otp_wr_addr;
	logic [7:0]  otp_wr_data;
	logic [7:0]  mem [128];
	logic [63:0] rx, e;
	int          mismatches, samples_checked, n, starts = 0, seed = 96;
	logic [7:0]  codes [7] = '{8'h02, 8'h9b, 8'h81, 8'h20, 8'h52, 8'h60, 8'hc7};
	int          lens [7] = '{40, 40, 32, 32, 32, 8, 8};

	fsotp_core i_fsotp_core (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .so(so),
		.so_oe_b(so_oe_b), .wp_b(wp_b), .core_busy(core_busy), .core_done(core_done), .core_fail(core_fail),
		.hold_abort(hold_abort), .soft_reset(soft_reset), .op_start(op_start), .op_code(op_code),
		.op_addr(op_addr), .otp_wr_en(otp_wr_en), .otp_wr_addr(otp_wr_addr), .otp_wr_data(otp_wr_data));
	fsotp_spi_host i_fsotp_spi_host (.cs_b(cs_b), .sck(sck), .si(si), .so(so), .so_oe_b(so_oe_b));

	always #12.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) if (op_start === 1'b1) begin
		starts   <= starts + 1;
		cap_code <= op_code;
		cap_addr <= op_addr;
	end

	// ****
	// Helpers
	// ****
	function automatic logic [7:0] b1(input logic busy);
		return {lock_e, 1'b0, err_e, wp_b, 1'b0, prot_e, wel_e, busy};
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask

	task automatic go(input logic [63:0] tx, input int ntx, input int nrx);
		i_fsotp_spi_host.frame(tx, ntx, nrx, rx, ok);
		`CHK(ok, 1'b1)
		// Realign to the system clock so later pin changes never race an edge
		tick(1);
	endtask

	task automatic stat(input logic busy);
		go(64'h05, 8, 24);
		`CHK(rx[23:16], b1(busy))
		`CHK(rx[15:8], {7'h0, busy})
		`CHK(rx[7:0], b1(busy))
	endtask

	task automatic wen();
		go(64'h06, 8, 0);
		wel_e = 1'b1;
	endtask

	task automatic engine(input logic [7:0] code, input logic [23:0] ad, input int ntx, input logic fail,
		input logic accept);
		int s0;
		s0 = starts;
		go(64'({code, ad, 8'ha5}) >> (40 - ntx), ntx, 0);
		// Latch drops as the frame closes, whether the op runs or is refused
		wel_e = 1'b0;
		`CHK(starts - s0, accept ? 1 : 0)
		if (accept) begin
			`CHK(cap_code, code)
			if (ntx > 8) `CHK(cap_addr, ad)
			core_busy = 1'b1;
			stat(1'b1);
			core_done = 1'b1;
			core_fail = fail;
			core_busy = 1'b0;
			tick(1);
			core_done = 1'b0;
			err_e     = fail;
			tick(2);
			stat(1'b0);
		end else begin
			// Refused write-type ops leave the error flag as it was
			stat(1'b0);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#400000;
		mismatches++;
		$display("Error %0t: watchdog expired", $time);
		final_report();
	end

	// ****
	// Main sequence
	// ****
	initial begin
		{clk_sys, rst_b, core_busy, core_done, core_fail, hold_abort, soft_reset} = '0;
		{otp_wr_en, otp_wr_addr, otp_wr_data, lock_e, prot_e, err_e, wel_e} = '0;
		wp_b = 1'b1;
		repeat (12) @(posedge clk_sys);
		#2 rst_b = 1'b1;
		tick(3);
		for (int i = 0; i < 128; i++) begin
			mem[i]      = 8'($random(seed));
			otp_wr_en   = 1'b1;
			otp_wr_addr = 7'(i);
			otp_wr_data = mem[i];
			tick(1);
		end
		otp_wr_en = 1'b0;
		stat(1'b0);
		$display("Test reset status done");
		for (int k = 0; k < 10; k++) begin
			a = (k == 0) ? 24'h00007e : 24'($random(seed));
			n = (k == 0) ? 32 : 1 + {$random(seed)} % 32;
			go(64'({8'h77, a, 16'h0}), 48, n);
			e = '0;
			for (int j = 0; j < n; j++) e = {e[62:0], mem[7'(a[6:0] + j / 8)][7 - j % 8]};
			`CHK(rx, e)
		end
		$display("Test security read done");
		wen();
		stat(1'b0);
		go(64'hab, 8, 0);
		stat(1'b0);
		go(64'h0, 4, 0);
		stat(1'b0);
		hold_abort = 1'b1;
		tick(1);
		hold_abort = 1'b0;
		wel_e      = 1'b0;
		tick(3);
		stat(1'b0);
		wen();
		soft_reset = 1'b1;
		tick(1);
		soft_reset = 1'b0;
		wel_e      = 1'b0;
		tick(3);
		stat(1'b0);
		wen();
		go(64'h04, 8, 0);
		wel_e = 1'b0;
		stat(1'b0);
		$display("Test write latch done");
		for (int k = 0; k < 7; k++) begin
			wen();
			engine(codes[k], (k == 1) ? 24'h0 : 24'($random(seed)), lens[k], 1'($random(seed)), 1'b1);
		end
		engine(8'h02, 24'h000100, 40, 1'b0, 1'b0);
		$display("Test engine done");
		go(64'h0184, 16, 0);
		stat(1'b0);
		wen();
		go(64'({8'h01, 1'b1, 4'($random(seed)), 1'b1, 2'($random(seed))}), 16, 0);
		{lock_e, prot_e, wel_e} = 3'b110;
		stat(1'b0);
		wen();
		engine(8'h20, 24'h001000, 32, 1'b0, 1'b0);
		wp_b = 1'b0;
		tick(4);
		stat(1'b0);
		foreach (codes[k]) if (k < 2) begin
			wen();
			go(64'({8'h01, (k == 0) ? 8'h80 : 8'h00}), 16, 0);
			wel_e = 1'b0;
			stat(1'b0);
		end
		wp_b = 1'b1;
		tick(4);
		wen();
		go(64'h0100, 16, 0);
		{lock_e, prot_e, wel_e} = 3'b000;
		stat(1'b0);
		$display("Test protection done");
		final_report();
	end
endmodule
